// file: inc/crxf_pkg.sv
/*
 Constants, register map and frame types of the CAN receive queue and
 acceptance filter. Assumes a CAN core on the same clock that hands over each
 finished frame as one pulse with an error flag.
*/
package crxf_pkg;
    localparam int NBANK = 6;
    localparam int DEPTH = 3;

    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_IRQEN  = 8'h04;
    localparam logic [7:0] A_QSTAT  = 8'h08;
    localparam logic [7:0] A_FMODE  = 8'h0C;
    localparam logic [7:0] A_FCFG   = 8'h10;
    localparam logic [7:0] A_MB_IDX = 8'h20;
    localparam logic [7:0] A_MB_DLC = 8'h24;
    localparam logic [7:0] A_MB_ID  = 8'h28;
    localparam logic [7:0] A_MB_D0  = 8'h2C;
    localparam logic [7:0] A_MB_D1  = 8'h30;
    localparam logic [7:0] A_FBASE  = 8'h40;
    localparam logic [7:0] A_FEND   = 8'h6F;

    localparam int B_LOCK = 0;
    localparam int B_INIT = 1;
    localparam int B_PEND_EN = 0;
    localparam int B_FULL_EN = 1;
    localparam int B_OVR_EN  = 2;
    localparam int B_REL  = 2;
    localparam int B_FULL = 3;
    localparam int B_OVR  = 4;
    localparam int B_MODE_HI = 8;

    localparam logic RST_INIT = 1'b1;

    localparam logic [1:0] SC_8   = 2'h0;
    localparam logic [1:0] SC_168 = 2'h1;
    localparam logic [1:0] SC_16  = 2'h2;
    localparam logic [1:0] SC_32  = 2'h3;

    localparam logic [31:0] CARE32 = 32'hFFFF_FFFE;
    localparam logic [31:0] CARE16 = 32'hFFF8_0000;
    localparam logic [31:0] CARE8  = 32'hFF00_0000;

    typedef enum logic [1:0] {
        FILL_EMPTY = 2'b00,
        FILL_P1    = 2'b01,
        FILL_P2    = 2'b10,
        FILL_P3    = 2'b11
    } crxf_fill_t;

    typedef struct packed {
        logic [10:0] std_id;
        logic        rtr;
        logic        ide;
        logic [17:0] ext_id;
        logic [3:0]  dlc;
        logic [63:0] data;
    } crxf_frame_t;

    typedef struct packed {
        crxf_frame_t frame;
        logic [5:0]  match_idx;
    } crxf_entry_t;
endpackage : crxf_pkg

// file: hdl/crxf_top.sv
/*
 CAN receive queue with six scalable acceptance filter banks, APB slave.
 Assumes the CAN core pulses RX_DONE on CORE_CLK once per frame, with RX_ERR
 and RX_FRAME valid in that cycle.
*/
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module crxf_top (
    input  wire logic                 CORE_CLK,
    input  wire logic                 RST,
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire logic [7:0]           PADDR,
    input  wire logic [31:0]          PWDATA,
    output logic      [31:0]          PRDATA,
    output logic                      PREADY,
    output logic                      PSLVERR,
    input  wire logic                 RX_DONE,
    input  wire logic                 RX_ERR,
    input  wire crxf_pkg::crxf_frame_t RX_FRAME,
    output logic                      IRQ_PENDING,
    output logic                      IRQ_FULL,
    output logic                      IRQ_OVERRUN
);
    logic                  pready_r;
    logic [31:0]           prdata_r;
    logic                  pslverr_r;
    logic                  rx_queue_lock_r;
    logic                  init_request_r;
    logic                  pend_en_r;
    logic                  full_en_r;
    logic                  ovr_en_r;
    logic [5:0]            mode_low_r;
    logic [5:0]            mode_high_r;
    logic [5:0]            bank_active_r;
    logic [1:0]            scale_r [0:5];
    logic [63:0]           fbyte_r [0:5];
    crxf_pkg::crxf_entry_t mem_r [0:2];
    logic [1:0]            wp_r;
    logic [1:0]            rp_r;
    crxf_pkg::crxf_fill_t  fill_r;
    crxf_pkg::crxf_fill_t  fill_nxt;
    logic                  full_flag_r;
    logic                  rx_overrun_flag_r;
    logic                  irq_pend_r;
    logic                  irq_full_r;
    logic                  irq_ovr_r;
    logic                  acc;
    logic                  wr;
    logic [31:0]           key;
    logic                  best_hit;
    logic [2:0]            best_sc;
    logic [5:0]            best_idx;
    logic                  valid_msg;
    logic                  rel;
    logic                  store;
    logic                  ovr;
    logic [1:0]            last_idx;
    logic [5:0]            foff;
    logic [31:0]           rdata_nxt;
    logic                  mapped;

    assign acc = PSEL & PENABLE & pready_r;
    assign wr  = acc & PWRITE;
    assign foff = 6'(PADDR - crxf_pkg::A_FBASE);
    assign key = {RX_FRAME.std_id, RX_FRAME.rtr, RX_FRAME.ide, RX_FRAME.ext_id, 1'b0};

    // List mode compares both identifiers, mask mode uses the second as mask.
    function automatic logic [1:0] f_hit(input logic [31:0] id, input logic [31:0] mk,
                                         input logic [31:0] k, input logic [31:0] care,
                                         input logic list);
        if (list) begin
            f_hit = {((k ^ id) & care) == 32'h0, ((k ^ mk) & care) == 32'h0};
        end else begin
            f_hit = {((k ^ id) & mk & care) == 32'h0, 1'b0};
        end
    endfunction : f_hit

    function automatic logic [1:0] f_inc(input logic [1:0] p);
        f_inc = (p == 2'h2) ? 2'h0 : 2'(p + 2'h1);
    endfunction : f_inc

    // Score = {list, width}; strict compare keeps the lowest bank and slot on ties.
    always_comb begin : filt
        logic [1:0] h;
        logic [7:0] sh;
        logic [2:0] sc [0:7];
        logic       ml;
        logic       mh;
        h = 2'h0;
        sh = 8'h00;
        ml = 1'b0;
        mh = 1'b0;
        for (int k = 0; k < 8; k++) begin
            sc[k] = 3'h0;
        end
        best_hit = 1'b0;
        best_sc = 3'h0;
        best_idx = 6'h00;
        for (int b = 0; b < crxf_pkg::NBANK; b++) begin
            sh = 8'h00;
            ml = mode_low_r[b];
            mh = mode_high_r[b];
            case (scale_r[b])
                crxf_pkg::SC_32: begin
                    h = f_hit(fbyte_r[b][63:32], fbyte_r[b][31:0], key, crxf_pkg::CARE32, mh);
                    sh[0] = h[1];
                    sh[4] = h[0];
                    sc[0] = {mh, 2'h3};
                    sc[4] = {mh, 2'h3};
                end
                crxf_pkg::SC_16: begin
                    h = f_hit({fbyte_r[b][63:48], 16'h0}, {fbyte_r[b][47:32], 16'h0},
                              key, crxf_pkg::CARE16, ml);
                    sh[0] = h[1];
                    sh[2] = h[0];
                    h = f_hit({fbyte_r[b][31:16], 16'h0}, {fbyte_r[b][15:0], 16'h0},
                              key, crxf_pkg::CARE16, mh);
                    sh[4] = h[1];
                    sh[6] = h[0];
                    sc[0] = {ml, 2'h2};
                    sc[2] = {ml, 2'h2};
                    sc[4] = {mh, 2'h2};
                    sc[6] = {mh, 2'h2};
                end
                crxf_pkg::SC_168: begin
                    h = f_hit({fbyte_r[b][63:48], 16'h0}, {fbyte_r[b][47:32], 16'h0},
                              key, crxf_pkg::CARE16, ml);
                    sh[0] = h[1];
                    sh[2] = h[0];
                    h = f_hit({fbyte_r[b][31:24], 24'h0}, {fbyte_r[b][23:16], 24'h0},
                              key, crxf_pkg::CARE8, mh);
                    sh[4] = h[1];
                    sh[5] = h[0];
                    h = f_hit({fbyte_r[b][15:8], 24'h0}, {fbyte_r[b][7:0], 24'h0},
                              key, crxf_pkg::CARE8, mh);
                    sh[6] = h[1];
                    sh[7] = h[0];
                    sc[0] = {ml, 2'h2};
                    sc[2] = {ml, 2'h2};
                    for (int k = 4; k < 8; k++) begin
                        sc[k] = {mh, 2'h1};
                    end
                end
                default: begin
                    for (int p = 0; p < 4; p++) begin
                        h = f_hit({fbyte_r[b][63-16*p -: 8], 24'h0},
                                  {fbyte_r[b][55-16*p -: 8], 24'h0},
                                  key, crxf_pkg::CARE8, (p < 2) ? ml : mh);
                        sh[2*p] = h[1];
                        sh[2*p+1] = h[0];
                        sc[2*p] = {(p < 2) ? ml : mh, 2'h1};
                        sc[2*p+1] = {(p < 2) ? ml : mh, 2'h1};
                    end
                end
            endcase
            for (int k = 0; k < 8; k++) begin
                if (bank_active_r[b] && sh[k] && (sc[k] > best_sc)) begin
                    best_hit = 1'b1;
                    best_sc = sc[k];
                    best_idx = {3'(b), 3'(k)};
                end
            end
        end
    end

    assign valid_msg = RX_DONE & ~RX_ERR & best_hit;
    assign rel = wr & (PADDR == crxf_pkg::A_QSTAT) & PWDATA[crxf_pkg::B_REL]
                 & (fill_r != crxf_pkg::FILL_EMPTY);
    // A release in the same cycle frees a slot, so that frame is not an overrun.
    assign store = valid_msg & ((fill_r != crxf_pkg::FILL_P3) | rel);
    assign ovr = valid_msg & (fill_r == crxf_pkg::FILL_P3) & ~rel;
    assign last_idx = (wp_r == 2'h0) ? 2'h2 : 2'(wp_r - 2'h1);

    always_comb begin
        case ({store, rel})
            2'b10: fill_nxt = crxf_pkg::crxf_fill_t'(2'(fill_r + 2'h1));
            2'b01: fill_nxt = crxf_pkg::crxf_fill_t'(2'(fill_r - 2'h1));
            default: fill_nxt = fill_r;
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (store) begin
            mem_r[wp_r] <= '{frame: RX_FRAME, match_idx: best_idx};
        end else if (ovr && !rx_queue_lock_r) begin
            mem_r[last_idx] <= '{frame: RX_FRAME, match_idx: best_idx};
        end
    end

    // Pointers move only on store and release; locked overruns set only the overrun flag.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            wp_r <= 2'h0;
            rp_r <= 2'h0;
            fill_r <= crxf_pkg::FILL_EMPTY;
        end else begin
            if (store) begin
                wp_r <= f_inc(wp_r);
            end
            if (rel) begin
                rp_r <= f_inc(rp_r);
            end
            fill_r <= fill_nxt;
        end
    end

    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            full_flag_r <= 1'b0;
            rx_overrun_flag_r <= 1'b0;
        end else begin
            if (store && fill_nxt == crxf_pkg::FILL_P3) begin
                full_flag_r <= 1'b1;
            end else if (wr && PADDR == crxf_pkg::A_QSTAT && PWDATA[crxf_pkg::B_FULL]) begin
                full_flag_r <= 1'b0;
            end
            if (ovr) begin
                rx_overrun_flag_r <= 1'b1;
            end else if (wr && PADDR == crxf_pkg::A_QSTAT && PWDATA[crxf_pkg::B_OVR]) begin
                rx_overrun_flag_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            irq_pend_r <= 1'b0;
            irq_full_r <= 1'b0;
            irq_ovr_r <= 1'b0;
        end else begin
            irq_pend_r <= pend_en_r & (fill_r != crxf_pkg::FILL_EMPTY);
            irq_full_r <= full_en_r & full_flag_r;
            irq_ovr_r <= ovr_en_r & rx_overrun_flag_r;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            rx_queue_lock_r <= 1'b0;
            init_request_r <= crxf_pkg::RST_INIT;
            pend_en_r <= 1'b0;
            full_en_r <= 1'b0;
            ovr_en_r <= 1'b0;
            mode_low_r <= 6'h00;
            mode_high_r <= 6'h00;
        end else if (wr) begin
            if (PADDR == crxf_pkg::A_CTRL) begin
                rx_queue_lock_r <= PWDATA[crxf_pkg::B_LOCK];
                init_request_r <= PWDATA[crxf_pkg::B_INIT];
            end
            if (PADDR == crxf_pkg::A_IRQEN) begin
                pend_en_r <= PWDATA[crxf_pkg::B_PEND_EN];
                full_en_r <= PWDATA[crxf_pkg::B_FULL_EN];
                ovr_en_r <= PWDATA[crxf_pkg::B_OVR_EN];
            end
            if (PADDR == crxf_pkg::A_FMODE && init_request_r) begin
                mode_low_r <= PWDATA[5:0];
                mode_high_r <= PWDATA[crxf_pkg::B_MODE_HI +: 6];
            end
        end
    end

    // Scale and filter-word changes to an active bank are ignored so the filter never sees a half update.
    for (genvar g = 0; g < crxf_pkg::NBANK; g++) begin : g_bank
        always_ff @(posedge CORE_CLK) begin
            if (RST) begin
                bank_active_r[g] <= 1'b0;
                scale_r[g] <= crxf_pkg::SC_8;
                fbyte_r[g] <= 64'h0;
            end else if (wr) begin
                if (PADDR == crxf_pkg::A_FCFG) begin
                    bank_active_r[g] <= PWDATA[4*g];
                    if (init_request_r && !bank_active_r[g]) begin
                        scale_r[g] <= PWDATA[4*g+1 +: 2];
                    end
                end
                if (PADDR >= crxf_pkg::A_FBASE && PADDR <= crxf_pkg::A_FEND
                    && foff[5:3] == 3'(g) && !bank_active_r[g]) begin
                    if (foff[2]) begin
                        fbyte_r[g][31:0] <= PWDATA;
                    end else begin
                        fbyte_r[g][63:32] <= PWDATA;
                    end
                end
            end
        end
    end

    always_comb begin
        rdata_nxt = 32'h0;
        mapped = 1'b1;
        case (PADDR)
            crxf_pkg::A_CTRL: rdata_nxt = {30'h0, init_request_r, rx_queue_lock_r};
            crxf_pkg::A_IRQEN: rdata_nxt = {29'h0, ovr_en_r, full_en_r, pend_en_r};
            crxf_pkg::A_QSTAT: rdata_nxt = {27'h0, rx_overrun_flag_r, full_flag_r, 1'b0, fill_r};
            crxf_pkg::A_FMODE: rdata_nxt = {18'h0, mode_high_r, 2'h0, mode_low_r};
            crxf_pkg::A_FCFG: begin
                for (int b = 0; b < crxf_pkg::NBANK; b++) begin
                    rdata_nxt[4*b +: 3] = {scale_r[b], bank_active_r[b]};
                end
            end
            crxf_pkg::A_MB_IDX: rdata_nxt = {26'h0, mem_r[rp_r].match_idx};
            crxf_pkg::A_MB_DLC: rdata_nxt = {28'h0, mem_r[rp_r].frame.dlc};
            crxf_pkg::A_MB_ID: rdata_nxt = {mem_r[rp_r].frame.std_id, mem_r[rp_r].frame.rtr,
                                            mem_r[rp_r].frame.ide, mem_r[rp_r].frame.ext_id,
                                            1'b0};
            crxf_pkg::A_MB_D0: rdata_nxt = mem_r[rp_r].frame.data[63:32];
            crxf_pkg::A_MB_D1: rdata_nxt = mem_r[rp_r].frame.data[31:0];
            default: begin
                if (PADDR >= crxf_pkg::A_FBASE && PADDR <= crxf_pkg::A_FEND) begin
                    rdata_nxt = foff[2] ? fbyte_r[foff[5:3]][31:0] : fbyte_r[foff[5:3]][63:32];
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    // One wait state: data and error are registered in the first access cycle.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= PSEL & PENABLE & ~pready_r;
            if (PSEL && PENABLE && !pready_r) begin
                prdata_r <= PWRITE ? 32'h0 : rdata_nxt;
                pslverr_r <= ~mapped;
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    assign PREADY = pready_r;
    assign PRDATA = prdata_r;
    assign PSLVERR = pslverr_r;
    assign IRQ_PENDING = irq_pend_r;
    assign IRQ_FULL = irq_full_r;
    assign IRQ_OVERRUN = irq_ovr_r;

    AST_FIRST: assert property (@(posedge CORE_CLK) disable iff (RST)
        fill_r == crxf_pkg::FILL_EMPTY && valid_msg |=> fill_r == crxf_pkg::FILL_P1)
        else $error("first message did not give one pending");
    AST_QUEUE: assert property (@(posedge CORE_CLK) disable iff (RST)
        fill_r == crxf_pkg::FILL_P1 && valid_msg && !rel |=> fill_r == crxf_pkg::FILL_P2)
        else $error("second message not queued");
    AST_RELEASE: assert property (@(posedge CORE_CLK) disable iff (RST)
        rel && !valid_msg |=> fill_r == 2'($past(fill_r) - 2'h1) && rp_r != $past(rp_r))
        else $error("release did not drop the oldest entry");
    AST_DROP: assert property (@(posedge CORE_CLK) disable iff (RST)
        RX_DONE && (RX_ERR || !best_hit) && !rel |=> $stable(fill_r) && $stable(wp_r))
        else $error("rejected or faulty frame was stored");
    AST_OVR: assert property (@(posedge CORE_CLK) disable iff (RST)
        ovr |=> rx_overrun_flag_r && fill_r == crxf_pkg::FILL_P3)
        else $error("overrun not flagged or count changed");
    AST_OVERWRITE: assert property (@(posedge CORE_CLK) disable iff (RST)
        ovr && !rx_queue_lock_r |=> mem_r[$past(last_idx)].frame == $past(RX_FRAME))
        else $error("newest entry not overwritten");
    AST_LOCKED: assert property (@(posedge CORE_CLK) disable iff (RST)
        ovr && rx_queue_lock_r |=> $stable(mem_r[last_idx]) && $stable(wp_r))
        else $error("locked queue was modified on overrun");
    AST_PEND_IRQ: assert property (@(posedge CORE_CLK) disable iff (RST)
        fill_r == crxf_pkg::FILL_EMPTY && valid_msg && pend_en_r ##1 pend_en_r |=> IRQ_PENDING)
        else $error("pending request missing");
    AST_FULL: assert property (@(posedge CORE_CLK) disable iff (RST)
        store && fill_nxt == crxf_pkg::FILL_P3 |=> full_flag_r ##1 (IRQ_FULL || !$past(full_en_r)))
        else $error("full flag or request missing");
    AST_OVR_IRQ: assert property (@(posedge CORE_CLK) disable iff (RST)
        ovr && ovr_en_r ##1 ovr_en_r |=> IRQ_OVERRUN)
        else $error("overrun request missing");
    AST_LIST_WINS: assert property (@(posedge CORE_CLK) disable iff (RST)
        valid_msg && best_sc[2] |-> mode_high_r[best_idx[5:3]] || mode_low_r[best_idx[5:3]])
        else $error("list-mode priority chose a mask-only bank");

    COV_OVERRUN: cover property (@(posedge CORE_CLK) disable iff (RST) ovr);
    COV_REL_STORE: cover property (@(posedge CORE_CLK) disable iff (RST) rel && store);
    COV_FULL: cover property (@(posedge CORE_CLK) disable iff (RST)
        store && fill_nxt == crxf_pkg::FILL_P3);
endmodule : crxf_top

// file: test/crxf_can_node.sv
/*
 Stand-in for the CAN core and the other nodes on the bus: it hands over one
 finished frame per call. Assumes the bench calls send from one process only.
*/
`timescale 1ns/1ps
module crxf_can_node (
    input  wire logic             clk,
    output logic                  rx_done,
    output logic                  rx_err,
    output crxf_pkg::crxf_frame_t rx_frame
);
    initial begin
        rx_done  = 1'b0;
        rx_err   = 1'b0;
        rx_frame = '0;
    end

    // Fields turn to junk after the pulse so a late sample cannot pass by luck.
    task automatic send(input crxf_pkg::crxf_frame_t f, input logic e);
        @(posedge clk);
        rx_done  <= 1'b1;
        rx_err   <= e;
        rx_frame <= f;
        @(posedge clk);
        rx_done  <= 1'b0;
        rx_err   <= ~e;
        rx_frame <= ~f;
    endtask : send
endmodule : crxf_can_node

// file: test/crxf_tb_top.sv
/*
 Self-checking bench of the receive queue and filters, APB master included.
 Assumes the design raises PREADY for every APB access; the master waits for it.
*/
`timescale 1ns/1ps
module crxf_tb_top;
    logic                  core_clk = 1'b0;
    logic                  rst = 1'b1;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [7:0]            paddr = 8'h00;
    logic [31:0]           pwdata = 32'h0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  rx_done;
    logic                  rx_err;
    crxf_pkg::crxf_frame_t rx_frame;
    logic                  irq_p;
    logic                  irq_f;
    logic                  irq_o;
    logic [32:0]           expq[$];
    crxf_pkg::crxf_frame_t f[8];
    crxf_pkg::crxf_frame_t bad;
    logic [15:0]           r = 16'hE821;
    int                    err_count = 0;
    int                    compares = 0;
    int                    cyc = 0;

    always #50 core_clk = ~core_clk;

    crxf_can_node node (.clk(core_clk), .rx_done(rx_done), .rx_err(rx_err), .rx_frame(rx_frame));

    crxf_top uut (.CORE_CLK(core_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .RX_DONE(rx_done), .RX_ERR(rx_err), .RX_FRAME(rx_frame),
        .IRQ_PENDING(irq_p), .IRQ_FULL(irq_f), .IRQ_OVERRUN(irq_o));

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    // Bit 32 of a note asks for a refusal, the data then being undefined.
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
        expq.push_back({err, e});
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic drain3(input int k0, input int k1, input int k2);
        int ks[3];
        ks = '{k0, k1, k2};
        foreach (ks[i]) begin
            rd(crxf_pkg::A_MB_D0, f[ks[i]].data[63:32], 1'b0);
            wr(crxf_pkg::A_QSTAT, 32'h4);
        end
    endtask : drain3

    always @(posedge core_clk) begin
        logic [32:0] n;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            n = expq.pop_front();
            if (n[32]) chk({31'h0, pslverr}, 32'h1);
            else chk(prdata, n[31:0]);
        end
    end

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            stop_test();
        end
    end

    initial begin
        for (int i = 0; i < 8; i++) begin
            f[i] = '0;
            f[i].std_id = 11'h123;
            f[i].ext_id = {2'h0, r};
            f[i].dlc = 4'h8;
            f[i].data = {r, lfsr(r), r, ~r};
            r = lfsr(lfsr(r));
        end
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        rd(crxf_pkg::A_QSTAT, 32'h0, 1'b0);
        rd(8'h18, 32'h0, 1'b1);
        wr(crxf_pkg::A_FBASE, 32'h2460_0000);
        wr(8'h44, 32'hFFE0_0000);
        wr(crxf_pkg::A_FCFG, 32'h6);
        wr(crxf_pkg::A_FCFG, 32'h7);
        wr(crxf_pkg::A_IRQEN, 32'h7);
        wr(crxf_pkg::A_CTRL, 32'h0);
        bad = f[0];
        node.send(bad, 1'b1);
        bad.std_id = 11'h456;
        node.send(bad, 1'b0);
        rd(crxf_pkg::A_QSTAT, 32'h0, 1'b0);
        $display("test filter done");
        node.send(f[0], 1'b0);
        rd(crxf_pkg::A_QSTAT, 32'h1, 1'b0);
        chk({31'h0, irq_p}, 32'h1);
        node.send(f[1], 1'b0);
        node.send(f[2], 1'b0);
        rd(crxf_pkg::A_QSTAT, 32'hB, 1'b0);
        chk({31'h0, irq_f}, 32'h1);
        node.send(f[3], 1'b0);
        rd(crxf_pkg::A_QSTAT, 32'h1B, 1'b0);
        chk({31'h0, irq_o}, 32'h1);
        rd(crxf_pkg::A_MB_IDX, 32'h0, 1'b0);
        drain3(0, 1, 3);
        rd(crxf_pkg::A_QSTAT, 32'h18, 1'b0);
        $display("test overwrite done");
        wr(crxf_pkg::A_CTRL, 32'h1);
        wr(crxf_pkg::A_QSTAT, 32'h18);
        for (int i = 4; i < 8; i++) node.send(f[i], 1'b0);
        rd(crxf_pkg::A_QSTAT, 32'h1B, 1'b0);
        drain3(4, 5, 6);
        $display("test lock done");
        wr(crxf_pkg::A_CTRL, 32'h2);
        wr(crxf_pkg::A_FMODE, 32'h200);
        wr(8'h4C, 32'h2460_0000);
        wr(crxf_pkg::A_FCFG, 32'h47);
        wr(crxf_pkg::A_FCFG, 32'h57);
        node.send(f[1], 1'b0);
        rd(crxf_pkg::A_MB_IDX, 32'hC, 1'b0);
        rd(crxf_pkg::A_MB_ID, {11'h123, 2'h0, f[1].ext_id, 1'b0}, 1'b0);
        wr(crxf_pkg::A_QSTAT, 32'h4);
        $display("test list done");
        repeat (3) @(posedge core_clk);
        stop_test();
    end
endmodule : crxf_tb_top
